//--- pbrb_pkg.sv
package pbrb_pkg;
  localparam logic [15:0] OFF_FRAME_BASE_0   = 16'hFF0C;
  localparam logic [15:0] OFF_FRAME_BASE_1   = 16'hFF10;
  localparam logic [15:0] OFF_DIRECT_ADDR    = 16'hFF14;
  localparam logic [15:0] OFF_DIRECT_DATA    = 16'hFF18;
  localparam logic [15:0] OFF_GP_PORT        = 16'hFF1C;
  localparam logic [15:0] OFF_TWO_WIRE       = 16'hFF20;
  localparam logic [15:0] OFF_WINDOW_SIZE    = 16'hFF24;
  localparam logic [15:0] OFF_DATA_OFFSETS   = 16'hFF28;
  localparam logic [15:0] OFF_HDEC_MASK      = 16'hFF2C;
  localparam logic [15:0] OFF_VDEC_MASK      = 16'hFF30;
  localparam logic [15:0] OFF_LINE_STRIDE    = 16'hFF34;
  localparam logic [15:0] OFF_FIFO_DATA      = 16'hFF40;
  localparam logic [15:0] OFF_IRQ_STATUS     = 16'hFF50;
  localparam logic [15:0] OFF_IRQ_CLEAR      = 16'hFF54;
  localparam logic [15:0] OFF_IRQ_ENABLE     = 16'hFF58;
  localparam logic [15:0] OFF_CONTROL        = 16'hFF5C;
  localparam int          FRAME_BASE_W       = 22;
  localparam int          DIRECT_ADDR_W      = 21;
  localparam int          DIRECT_TYPE_LSB    = 21;
  localparam int          DIRECT_TYPE_W      = 3;
  localparam int          GP_W               = 4;
  localparam int          GP_IN_LSB          = 4;
  localparam int          TW_CLK_BIT         = 0;
  localparam int          TW_DAT_BIT         = 1;
  localparam int          TW_CLK_SENSE_BIT   = 2;
  localparam int          TW_DAT_SENSE_BIT   = 3;
  localparam int          TW_ENABLE_BIT      = 4;
  localparam int          TW_MIRROR_LSB      = 8;
  localparam int          TW_MIRROR_W        = 5;
  localparam int          WIDTH_W            = 12;
  localparam int          HEIGHT_LSB         = 16;
  localparam int          HEIGHT_W           = 9;
  localparam int          VDEC_W             = 8;
  localparam int          STRIDE_W           = 12;
  localparam int          CTL_HOLD_START_BIT = 24;
  localparam int          IRQ_FIFO_BIT       = 0;
  localparam int          IRQ_START_BIT      = 1;
  localparam int          IRQ_W              = 2;
  localparam int          FIFO_DEPTH         = 4;
  localparam logic [31:0] RESET_ZERO         = 32'h0000_0000;
endpackage

//--- pbrb_top.sv
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module pbrb_top
  import pbrb_pkg::*;
#(
  parameter int DEPTH = pbrb_pkg::FIFO_DEPTH
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  output logic      [3:0]  gp_out,
  input  wire logic [3:0]  gp_in,
  input  wire logic [4:0]  lane2_data,
  input  wire logic [7:0]  vdec_mask_in,
  input  wire logic        serial_clock_pin_in,
  output logic             serial_clock_pin_out,
  output logic             serial_clock_pin_oe,
  input  wire logic        serial_data_in,
  output logic             serial_data_out,
  output logic             serial_data_oe,
  input  wire logic        line_boundary,
  output logic      [21:0] capture_addr,
  output logic      [31:0] fifo_out_data,
  output logic             fifo_out_valid,
  input  wire logic        fifo_out_ready,
  output logic             fifo_full,
  output logic             fifo_empty
);
  import pbrb_pkg::*;

  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [31:0]            prdata;
    logic                   pready;
    logic                   pslverr;
    logic [21:0]            base0;
    logic [21:0]            base1;
    logic [23:0]            daddr;
    logic [31:0]            ddata;
    logic [3:0]             gp;
    logic                   tw_clk;
    logic                   tw_dat;
    logic                   tw_en;
    logic                   hold_start;
    logic                   held;
    logic [11:0]            width;
    logic [8:0]             height;
    logic [11:0]            hoff;
    logic [8:0]             voff;
    logic [31:0]            hdec;
    logic [11:0]            stride;
    logic [21:0]            cap_addr;
    logic [1:0]             sync_clk_a;
    logic [1:0]             sync_clk_b;
    logic [1:0]             sync_dat_a;
    logic [1:0]             sync_dat_b;
    logic [3:0]             sync_gp_a;
    logic [3:0]             sync_gp_b;
    logic [4:0]             sync_l2_a;
    logic [4:0]             sync_l2_b;
    logic [7:0]             sync_vd_a;
    logic [7:0]             sync_vd_b;
    logic                   sync_lb_a;
    logic                   sync_lb_b;
    logic                   lb_prev;
    logic [IRQ_W-1:0]       status;
    logic [IRQ_W-1:0]       enable;
    logic                   irq;
    logic [DEPTH-1:0][31:0] mem;
    logic [PW:0]            wptr;
    logic [PW:0]            rptr;
  } pbrb_state_t;

  pbrb_state_t st;
  pbrb_state_t next_st;

  function automatic logic hit(input logic [15:0] a, input logic [15:0] off);
    return a == off;
  endfunction

  logic [PW:0] count;
  logic        wr_acc;
  logic        rd_acc;
  logic        start_seen;
  logic        push;
  logic        pop;
  logic        mapped;
  logic [IRQ_W-1:0] events;

  always_comb begin
    next_st = st;
    count   = st.wptr - st.rptr;
    wr_acc  = psel && penable && pwrite && !st.pready;
    rd_acc  = psel && penable && !pwrite && !st.pready;
    next_st.pready  = psel && penable && !st.pready;
    next_st.pslverr = 1'b0;
    // Synchronise every pin input through two flops, four for the serial clock and data
    next_st.sync_clk_a = {st.sync_clk_a[0], serial_clock_pin_in};
    next_st.sync_dat_a = {st.sync_dat_a[0], serial_data_in};
    next_st.sync_clk_b = {st.sync_clk_b[0], st.sync_clk_a[1]};
    next_st.sync_dat_b = {st.sync_dat_b[0], st.sync_dat_a[1]};
    next_st.sync_gp_a  = gp_in;
    next_st.sync_gp_b  = st.sync_gp_a;
    next_st.sync_l2_a  = lane2_data;
    next_st.sync_l2_b  = st.sync_l2_a;
    next_st.sync_vd_a  = vdec_mask_in;
    next_st.sync_vd_b  = st.sync_vd_a;
    next_st.sync_lb_a  = line_boundary;
    next_st.sync_lb_b  = st.sync_lb_a;
    next_st.lb_prev    = st.sync_lb_b;
    // Start: data falls while clock high, only while port enabled
    start_seen = st.tw_en && st.sync_clk_b[1] && st.sync_clk_b[0]
                 && st.sync_dat_b[1] && !st.sync_dat_b[0];
    if (start_seen && st.hold_start)
      next_st.held = 1'b1;
    // Line boundary steps the capture address by the stride
    if (st.sync_lb_b && !st.lb_prev)
      next_st.cap_addr = st.cap_addr + {10'h000, st.stride};
    // Output FIFO push and drain
    pop  = fifo_out_ready && (count != '0);
    push = wr_acc && hit(paddr, OFF_FIFO_DATA) && (count != (PW+1)'(DEPTH));
    if (push) begin
      next_st.mem[st.wptr[PW-1:0]] = pwdata;
      next_st.wptr = st.wptr + 1'b1;
    end
    if (pop)
      next_st.rptr = st.rptr + 1'b1;
    events = '0;
    events[IRQ_START_BIT] = start_seen;
    events[IRQ_FIFO_BIT]  = pop && (count == (PW+1)'(1));
    mapped = 1'b1;
    if (wr_acc) begin
      case (paddr)
        OFF_FRAME_BASE_0: next_st.base0 = pwdata[FRAME_BASE_W-1:0];
        OFF_FRAME_BASE_1: next_st.base1 = pwdata[FRAME_BASE_W-1:0];
        OFF_DIRECT_ADDR:  next_st.daddr = pwdata[23:0];
        OFF_DIRECT_DATA:  next_st.ddata = pwdata;
        OFF_GP_PORT:      next_st.gp = pwdata[GP_W-1:0];
        OFF_TWO_WIRE: begin
          next_st.tw_clk = pwdata[TW_CLK_BIT];
          next_st.tw_dat = pwdata[TW_DAT_BIT];
          next_st.tw_en  = pwdata[TW_ENABLE_BIT];
          // A start seen in the same cycle keeps the clock held
          if (pwdata[TW_CLK_BIT] && !(start_seen && st.hold_start))
            next_st.held = 1'b0;
        end
        OFF_WINDOW_SIZE: begin
          next_st.width  = pwdata[WIDTH_W-1:0];
          next_st.height = pwdata[HEIGHT_LSB +: HEIGHT_W];
        end
        OFF_DATA_OFFSETS: begin
          next_st.hoff = pwdata[WIDTH_W-1:0];
          next_st.voff = pwdata[HEIGHT_LSB +: HEIGHT_W];
        end
        OFF_HDEC_MASK:    next_st.hdec = pwdata;
        OFF_VDEC_MASK:    mapped = 1'b1;
        OFF_LINE_STRIDE:  next_st.stride = pwdata[STRIDE_W-1:0];
        OFF_FIFO_DATA:    mapped = 1'b1;
        OFF_IRQ_STATUS:   mapped = 1'b1;
        OFF_IRQ_CLEAR:    next_st.status = st.status & ~pwdata[IRQ_W-1:0];
        OFF_IRQ_ENABLE:   next_st.enable = pwdata[IRQ_W-1:0];
        OFF_CONTROL: begin
          next_st.hold_start = pwdata[CTL_HOLD_START_BIT];
          next_st.cap_addr   = pwdata[0] ? st.base1 : st.base0;
        end
        default:          mapped = 1'b0;
      endcase
      next_st.pslverr = !mapped;
    end
    // Set wins over clear
    next_st.status = next_st.status | events;
    next_st.irq    = |(next_st.status & st.enable);
    if (rd_acc) begin
      next_st.prdata = RESET_ZERO;
      case (paddr)
        OFF_FRAME_BASE_0: next_st.prdata[FRAME_BASE_W-1:0] = st.base0;
        OFF_FRAME_BASE_1: next_st.prdata[FRAME_BASE_W-1:0] = st.base1;
        OFF_DIRECT_ADDR:  next_st.prdata[23:0] = st.daddr;
        OFF_DIRECT_DATA:  next_st.prdata = st.ddata;
        OFF_GP_PORT: begin
          next_st.prdata[GP_W-1:0]         = st.gp;
          next_st.prdata[GP_IN_LSB +: GP_W] = st.sync_gp_b;
        end
        OFF_TWO_WIRE: begin
          next_st.prdata[TW_CLK_BIT]       = st.tw_clk;
          next_st.prdata[TW_DAT_BIT]       = st.tw_dat;
          next_st.prdata[TW_CLK_SENSE_BIT] = st.sync_clk_a[1];
          next_st.prdata[TW_DAT_SENSE_BIT] = st.sync_dat_a[1];
          next_st.prdata[TW_ENABLE_BIT]    = st.tw_en;
          next_st.prdata[TW_MIRROR_LSB +: TW_MIRROR_W] = st.sync_l2_b;
        end
        OFF_WINDOW_SIZE: begin
          next_st.prdata[WIDTH_W-1:0]           = st.width;
          next_st.prdata[HEIGHT_LSB +: HEIGHT_W] = st.height;
        end
        OFF_DATA_OFFSETS: begin
          next_st.prdata[WIDTH_W-1:0]           = st.hoff;
          next_st.prdata[HEIGHT_LSB +: HEIGHT_W] = st.voff;
        end
        OFF_HDEC_MASK:    next_st.prdata = st.hdec;
        OFF_VDEC_MASK:    next_st.prdata[VDEC_W-1:0] = st.sync_vd_b;
        OFF_LINE_STRIDE:  next_st.prdata[STRIDE_W-1:0] = st.stride;
        OFF_FIFO_DATA:    next_st.prdata = {{(31-PW){1'b0}}, count};
        OFF_IRQ_STATUS:   next_st.prdata[IRQ_W-1:0] = st.status;
        OFF_IRQ_CLEAR:    next_st.prdata = RESET_ZERO;
        OFF_IRQ_ENABLE:   next_st.prdata[IRQ_W-1:0] = st.enable;
        OFF_CONTROL: begin
          next_st.prdata[CTL_HOLD_START_BIT] = st.hold_start;
          next_st.prdata[1]                  = st.held;
        end
        default:          next_st.pslverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st        <= '0;
      st.tw_clk <= 1'b1;
      st.tw_dat <= 1'b1;
      st.sync_clk_a <= 2'h3;
      st.sync_clk_b <= 2'h3;
      st.sync_dat_a <= 2'h3;
      st.sync_dat_b <= 2'h3;
    end else begin
      st <= next_st;
    end
  end

  // Pins: open drain, enable high while pulling low
  logic [PW:0] occ;
  always_comb begin
    occ = st.wptr - st.rptr;
  end

  always_comb begin
    prdata               = st.prdata;
    pready               = st.pready;
    pslverr              = st.pslverr;
    irq                  = st.irq;
    gp_out               = st.gp;
    serial_clock_pin_out = 1'b0;
    serial_clock_pin_oe  = st.tw_en && (!st.tw_clk || st.held);
    serial_data_out      = 1'b0;
    serial_data_oe       = st.tw_en && !st.tw_dat;
    capture_addr         = st.cap_addr;
    fifo_out_data        = st.mem[st.rptr[PW-1:0]];
    fifo_out_valid       = occ != '0;
    fifo_full            = occ == (PW+1)'(DEPTH);
    fifo_empty           = occ == '0;
  end
endmodule
`default_nettype wire

//--- pbrb_partner.sv
`timescale 1ns/1ns
`default_nettype none
module pbrb_partner (
  input  wire logic        pclk,
  input  wire logic        serial_clock_pin_oe,
  input  wire logic        serial_data_oe,
  input  wire logic        dat_pull,
  input  wire logic        stall,
  input  wire logic        fifo_out_valid,
  input  wire logic [31:0] fifo_out_data,
  output logic             serial_clock_pin_in,
  output logic             serial_data_in,
  output logic             fifo_out_ready,
  output logic      [31:0] pops,
  output logic      [31:0] last_word
);
  // Pulled-up lines, low while any party pulls
  assign serial_clock_pin_in = !serial_clock_pin_oe;
  assign serial_data_in      = !(serial_data_oe || dat_pull);
  // Takes a word whenever offered unless stalled
  assign fifo_out_ready      = fifo_out_valid && !stall;
  initial pops = '0;
  always @(posedge pclk) begin
    if (fifo_out_valid && fifo_out_ready) begin
      pops      <= pops + 32'h1;
      last_word <= fifo_out_data;
    end
  end
endmodule
`default_nettype wire

//--- pbrb_top_chk.sv
`timescale 1ns/1ns
`default_nettype none
module pbrb_chk
  import pbrb_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [15:0] paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [3:0]  gp_out,
  input wire logic        serial_clock_pin_out,
  input wire logic        serial_data_out,
  input wire logic        fifo_out_valid,
  input wire logic        fifo_full,
  input wire logic        fifo_empty
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc   = psel && penable && !pready;
  wire gp_wr = acc && pwrite && paddr == OFF_GP_PORT;
  wire ff_wr = acc && pwrite && paddr == OFF_FIFO_DATA;
  ready_timing_a: assert property (acc |=> pready) else $error("late answer");
  ready_pulse_a: assert property (pready |=> !pready) else $error("long ready");
  err_with_ready_a: assert property (pslverr |-> pready) else $error("lone error");
  ro_no_err_a: assert property (acc && paddr == OFF_VDEC_MASK |=> !pslverr)
    else $error("read-only place refused");
  pins_low_a: assert property (!serial_clock_pin_out && !serial_data_out)
    else $error("pin driven high");
  fifo_flags_a: assert property (fifo_out_valid == !fifo_empty && !(fifo_full && fifo_empty))
    else $error("fifo flags disagree");
  fifo_push_a: assert property (ff_wr && fifo_empty |=> ##[0:2] !fifo_empty)
    else $error("word not pushed");
  gp_change_a: assert property ($changed(gp_out) |-> $past(gp_wr) || $past(gp_wr, 2))
    else $error("outputs changed unasked");
endmodule
bind pbrb_top pbrb_chk chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pready,
  .pslverr, .gp_out, .serial_clock_pin_out, .serial_data_out, .fifo_out_valid, .fifo_full,
  .fifo_empty);
`default_nettype wire

//--- peripheral_bus_register_bank_test.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b, m) begin tests_run++; if ((a) !== (b)) begin failures++; \
  $display("CHECK FAILED at %0t: %s", $time, m); end end
module peripheral_bus_register_bank_test;
  import pbrb_pkg::*;
  localparam int DEPTH = 4;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [15:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rdata, fifo_out_data, pops, last_word;
  logic        pready, pslverr, rerr, irq, serial_clock_pin_in, serial_data_in;
  logic        serial_clock_pin_oe, serial_data_oe, fifo_out_valid, fifo_out_ready;
  logic        fifo_full, fifo_empty, line_boundary = 0, dat_pull = 0, stall = 0;
  logic [3:0]  gp_out, gp_in = '0;
  logic [4:0]  lane2_data = '0;
  logic [7:0]  vdec_mask_in = '0;
  logic [21:0] capture_addr;
  int          failures = 0, tests_run = 0, cycles = 0;
  pbrb_top #(.DEPTH(DEPTH)) dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .irq, .gp_out, .gp_in, .lane2_data, .vdec_mask_in,
    .serial_clock_pin_in, .serial_clock_pin_out(), .serial_clock_pin_oe, .serial_data_in,
    .serial_data_out(), .serial_data_oe, .line_boundary, .capture_addr, .fifo_out_data,
    .fifo_out_valid, .fifo_out_ready, .fifo_full, .fifo_empty);
  pbrb_partner far_u (.pclk, .serial_clock_pin_oe, .serial_data_oe, .dat_pull, .stall,
    .fifo_out_valid, .fifo_out_data, .serial_clock_pin_in, .serial_data_in,
    .fifo_out_ready, .pops, .last_word);
  always #10 pclk = ~pclk;
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic start_cond();
    dat_pull <= 1'b1;
    repeat (4) @(posedge pclk);
    dat_pull <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask
  task automatic t_regs();
    logic [15:0] a[8] = '{OFF_FRAME_BASE_0, OFF_FRAME_BASE_1, OFF_DIRECT_ADDR,
      OFF_DIRECT_DATA, OFF_WINDOW_SIZE, OFF_DATA_OFFSETS, OFF_HDEC_MASK, OFF_LINE_STRIDE};
    logic [31:0] v[8] = '{32'h003F_FFFF, 32'h002A_AAAA, 32'h00FF_FFFF, 32'hFFFF_FFFF,
      32'h01FF_0FFF, 32'h01AA_0ABC, 32'hA5A5_5A5A, 32'h0000_0FFF};
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, a[i], v[i]);
      apb(1'b0, a[i], '0);
      `CHK(rdata, v[i], "register readback")
    end
  endtask
  task automatic t_ports();
    gp_in        <= 4'h5;
    lane2_data   <= 5'h15;
    vdec_mask_in <= 8'h5A;
    apb(1'b1, OFF_GP_PORT, 32'h0000_00FA);
    `CHK(gp_out, 4'hA, "general outputs")
    apb(1'b0, OFF_GP_PORT, '0);
    `CHK(rdata[7:0], 8'h5A, "general port read")
    apb(1'b1, OFF_VDEC_MASK, '0);
    apb(1'b0, OFF_VDEC_MASK, '0);
    `CHK({rerr, rdata[7:0]}, 9'h05A, "line mask kept")
    apb(1'b0, OFF_TWO_WIRE, '0);
    `CHK(rdata[12:8], 5'h15, "lane mirror")
    apb(1'b0, 16'hFF3C, '0);
    `CHK(rerr, 1'b1, "unmapped access")
  endtask
  task automatic t_serial();
    apb(1'b1, OFF_TWO_WIRE, 32'h0000_0003);
    start_cond();
    apb(1'b0, OFF_IRQ_STATUS, '0);
    `CHK(rdata[1], 1'b0, "start ignored while off")
    apb(1'b1, OFF_CONTROL, 32'h0100_0000);
    apb(1'b1, OFF_TWO_WIRE, 32'h0000_0012);
    `CHK(serial_clock_pin_in, 1'b0, "clock driven low")
    apb(1'b0, OFF_TWO_WIRE, '0);
    `CHK(rdata[3:2], 2'b10, "pin sense")
    apb(1'b1, OFF_TWO_WIRE, 32'h0000_0013);
    start_cond();
    `CHK({serial_clock_pin_in, irq}, 2'b00, "clock held, irq masked")
    apb(1'b1, OFF_IRQ_ENABLE, 32'h0000_0002);
    `CHK(irq, 1'b1, "start raises irq")
    apb(1'b1, OFF_IRQ_CLEAR, 32'h0000_0002);
    apb(1'b1, OFF_TWO_WIRE, 32'h0000_0013);
    `CHK({serial_clock_pin_in, irq}, 2'b10, "clock freed, irq cleared")
  endtask
  task automatic t_fifo();
    stall <= 1'b1;
    for (int i = 0; i <= DEPTH; i++) apb(1'b1, OFF_FIFO_DATA, 32'hC0DE_0000 + i);
    `CHK(fifo_full, 1'b1, "fifo full")
    apb(1'b0, OFF_FIFO_DATA, '0);
    `CHK(rdata, 32'(DEPTH), "extra word dropped")
    apb(1'b1, OFF_IRQ_ENABLE, 32'h0000_0001);
    stall <= 1'b0;
    for (int n = 0; n < 50 && fifo_empty !== 1'b1; n++) @(posedge pclk);
    repeat (3) @(posedge pclk);
    `CHK({pops, last_word}, {32'(DEPTH), 32'hC0DE_0003}, "words delivered")
    `CHK(irq, 1'b1, "drained irq")
  endtask
  task automatic t_stride();
    apb(1'b1, OFF_LINE_STRIDE, 32'h0000_0010);
    apb(1'b1, OFF_FRAME_BASE_1, 32'h0000_0100);
    apb(1'b1, OFF_CONTROL, 32'h0000_0001);
    `CHK(capture_addr, 22'h000100, "base loaded")
    repeat (2) begin
      line_boundary <= 1'b1;
      repeat (4) @(posedge pclk);
      line_boundary <= 1'b0;
      repeat (4) @(posedge pclk);
    end
    `CHK(capture_addr, 22'h000120, "stride per line")
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge pclk) begin
    cycles++;
    if (cycles > 20000) begin
      failures++;
      report_and_stop();
    end
  end
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_ports();
    t_serial();
    t_fifo();
    t_stride();
    report_and_stop();
  end
endmodule
`default_nettype wire
